// File: core/fcpwm_top.sv
// Four-channel pulse-width modulator with shared down counter and brake.
//
// Implementation choices: the plain strobed port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
`include "fcpwm_consts.svh"

module fcpwm_top #(
    parameter int CHANNELS = 4
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic reset_level_high_select,
    input wire logic brake_pin,
    input wire logic [`FCPWM_ADDR_W-1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    output logic [CHANNELS-1:0] pwm_out,
    output logic irq
);

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    logic brk_s1_r;
    logic brk_s2_r;
    logic lvl_s1_r;
    logic lvl_s2_r;

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            brk_s1_r <= 1'b0;
            brk_s2_r <= 1'b0;
        end else if (clk_en) begin
            brk_s1_r <= brake_pin;
            brk_s2_r <= brk_s1_r;
        end
    end

    // The strap synchroniser keeps running through reset, so the level is settled when reset ends.
    always_ff @(posedge sys_clk) begin
        if (clk_en) begin
            lvl_s1_r <= reset_level_high_select;
            lvl_s2_r <= lvl_s1_r;
        end
    end

    // ----------------------------------------------------------------
    // Software registers
    // ----------------------------------------------------------------
    logic run_r;
    logic load_r;
    logic uf_flag_r;
    logic sw_brake_r;
    logic brake_polarity_select_r;
    logic bkf_r;
    logic bkie_r;
    logic [7:0] per_lo_r;
    logic [1:0] per_hi_r;
    logic [7:0] cmp_lo_r [CHANNELS];
    logic [1:0] cmp_hi_r [CHANNELS];
    logic [1:0] irq_stat_r;
    logic [1:0] irq_mask_r;

    // ----------------------------------------------------------------
    // Counter datapath
    // ----------------------------------------------------------------
    fcpwm_pkg::fcpwm_cnt_t cnt_r;
    fcpwm_pkg::fcpwm_cnt_t hold_r;
    fcpwm_pkg::fcpwm_cnt_t act_cmp_r [CHANNELS];
    fcpwm_pkg::fcpwm_state_t state_r;
    logic init_r;
    logic pend_cmp_r;

    wire fcpwm_pkg::fcpwm_cnt_t period_value = {per_hi_r, per_lo_r};
    wire pin_brake = brake_polarity_select_r ? brk_s2_r : ~brk_s2_r;
    wire brake_act = pin_brake | sw_brake_r;
    wire counting = run_r & ~brake_act;
    wire underflow = counting & (cnt_r == 10'h000);
    wire do_load = run_r & load_r & uf_flag_r;

    wire wr_ctrl1 = reg_wr && (reg_addr == `FCPWM_OFF_CTRL1);
    wire wr_ctrl2 = reg_wr && (reg_addr == `FCPWM_OFF_CTRL2);
    wire wr_ctrl3 = reg_wr && (reg_addr == `FCPWM_OFF_CTRL3);
    wire wr_plo = reg_wr && (reg_addr == `FCPWM_OFF_PER_LO);
    wire wr_phi = reg_wr && (reg_addr == `FCPWM_OFF_PER_HI);
    wire wr_stat = reg_wr && (reg_addr == `FCPWM_OFF_IRQ_STAT);
    wire wr_mask = reg_wr && (reg_addr == `FCPWM_OFF_IRQ_MASK);

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            per_lo_r <= 8'hff;
            per_hi_r <= 2'h3;
        end else if (clk_en) begin
            if (wr_plo) begin
                per_lo_r <= reg_wdata;
            end
            if (wr_phi) begin
                per_hi_r <= reg_wdata[1:0];
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            sw_brake_r <= 1'b0;
            brake_polarity_select_r <= 1'b0;
            bkie_r <= 1'b0;
        end else if (clk_en) begin
            if (wr_ctrl2) begin
                brake_polarity_select_r <= reg_wdata[`FCPWM_BIT_BRAKE_POLARITY_SELECT];
                sw_brake_r <= reg_wdata[`FCPWM_BIT_SWBRK];
            end
            if (wr_ctrl3) begin
                bkie_r <= reg_wdata[`FCPWM_BIT_BKIE];
            end
        end
    end

    // Brake pin clears run; a pin brake also wins over a run write in the same cycle.
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            run_r <= 1'b0;
        end else if (clk_en) begin
            if (pin_brake) begin
                run_r <= 1'b0;
            end else if (wr_ctrl1) begin
                run_r <= reg_wdata[`FCPWM_BIT_RUN];
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            load_r <= 1'b0;
            cnt_r <= `FCPWM_PERIOD_RST;
            hold_r <= `FCPWM_PERIOD_RST;
            pend_cmp_r <= 1'b0;
        end else if (clk_en) begin
            if (do_load) begin
                load_r <= 1'b0;
                hold_r <= period_value;
                cnt_r <= hold_r;
            end else begin
                if (wr_ctrl1 && reg_wdata[`FCPWM_BIT_LOAD]) begin
                    load_r <= 1'b1;
                    pend_cmp_r <= 1'b1;
                end
                if (underflow) begin
                    cnt_r <= hold_r;
                end else if (counting) begin
                    cnt_r <= cnt_r - 10'h001;
                end
            end
            if (underflow) begin
                pend_cmp_r <= 1'b0;
            end
        end
    end

    // Hardware set wins over a software clear in the same cycle.
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            uf_flag_r <= 1'b0;
            bkf_r <= 1'b0;
        end else if (clk_en) begin
            if (underflow) begin
                uf_flag_r <= 1'b1;
            end else if (wr_ctrl1 && !reg_wdata[`FCPWM_BIT_UF]) begin
                uf_flag_r <= 1'b0;
            end
            if (pin_brake) begin
                bkf_r <= 1'b1;
            end else if (wr_ctrl3 && !reg_wdata[`FCPWM_BIT_BKF]) begin
                bkf_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            irq_stat_r <= 2'h0;
            irq_mask_r <= 2'h0;
        end else if (clk_en) begin
            irq_stat_r[`FCPWM_IRQ_UF] <= underflow |
                (irq_stat_r[`FCPWM_IRQ_UF] & ~(wr_stat & reg_wdata[`FCPWM_IRQ_UF]));
            irq_stat_r[`FCPWM_IRQ_BRK] <= (pin_brake & ~bkf_r) |
                (irq_stat_r[`FCPWM_IRQ_BRK] & ~(wr_stat & reg_wdata[`FCPWM_IRQ_BRK]));
            if (wr_mask) begin
                irq_mask_r <= reg_wdata[1:0];
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            state_r <= fcpwm_pkg::FCPWM_IDLE;
        end else if (clk_en) begin
            case (state_r)
                fcpwm_pkg::FCPWM_IDLE: begin
                    if (counting) begin
                        state_r <= fcpwm_pkg::FCPWM_RUN;
                    end
                end
                fcpwm_pkg::FCPWM_RUN: begin
                    if (brake_act) begin
                        state_r <= fcpwm_pkg::FCPWM_BRAKE;
                    end else if (!run_r) begin
                        state_r <= fcpwm_pkg::FCPWM_IDLE;
                    end
                end
                default: begin
                    if (!brake_act) begin
                        state_r <= run_r ? fcpwm_pkg::FCPWM_RUN : fcpwm_pkg::FCPWM_IDLE;
                    end
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Channels
    // ----------------------------------------------------------------
    // Outputs freeze during brake so they resume the pre-brake level afterwards.
    wire frozen = (state_r == fcpwm_pkg::FCPWM_BRAKE) | brake_act;

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            init_r <= 1'b1;
        end else if (clk_en) begin
            init_r <= 1'b0;
        end
    end

    genvar ch;
    generate
        for (ch = 0; ch < CHANNELS; ch = ch + 1) begin : g_ch
            wire [`FCPWM_ADDR_W-1:0] lo_off = `FCPWM_OFF_CMP_LO0 + ch[`FCPWM_ADDR_W-1:0];
            wire [`FCPWM_ADDR_W-1:0] hi_off = `FCPWM_OFF_CMP_HI0 + ch[`FCPWM_ADDR_W-1:0];
            wire wr_lo = reg_wr && (reg_addr == lo_off);
            wire wr_hi = reg_wr && (reg_addr == hi_off);
            // Compare of zero is never above the counter; all ones is forced low even at the top count.
            wire out_high = (act_cmp_r[ch] != 10'h3ff) && !(act_cmp_r[ch] > cnt_r);

            always_ff @(posedge sys_clk) begin
                if (!rst_n) begin
                    cmp_lo_r[ch] <= 8'h00;
                    cmp_hi_r[ch] <= 2'h0;
                    act_cmp_r[ch] <= `FCPWM_CMP_RST;
                    pwm_out[ch] <= 1'b0;
                end else if (clk_en) begin
                    if (wr_lo) begin
                        cmp_lo_r[ch] <= reg_wdata;
                    end
                    if (wr_hi) begin
                        cmp_hi_r[ch] <= reg_wdata[1:0];
                    end
                    if (underflow && pend_cmp_r) begin
                        act_cmp_r[ch] <= {cmp_hi_r[ch], cmp_lo_r[ch]};
                    end
                    if (init_r) begin
                        pwm_out[ch] <= lvl_s2_r;
                    end else if (counting && !frozen) begin
                        pwm_out[ch] <= out_high;
                    end
                end
            end
        end
    endgenerate

    // ----------------------------------------------------------------
    // Read mux and interrupt
    // ----------------------------------------------------------------
    logic [7:0] rd_mux;

    always_comb begin
        rd_mux = 8'h00;
        if (reg_addr == `FCPWM_OFF_CTRL1) begin
            rd_mux = {run_r, load_r, uf_flag_r, 5'h00};
        end else if (reg_addr == `FCPWM_OFF_CTRL2) begin
            rd_mux = {1'b0, brake_polarity_select_r, 5'h00, sw_brake_r};
        end else if (reg_addr == `FCPWM_OFF_CTRL3) begin
            rd_mux = {6'h00, bkie_r, bkf_r};
        end else if (reg_addr == `FCPWM_OFF_PER_LO) begin
            rd_mux = per_lo_r;
        end else if (reg_addr == `FCPWM_OFF_PER_HI) begin
            rd_mux = {6'h00, per_hi_r};
        end else if (reg_addr >= `FCPWM_OFF_CMP_LO0 && reg_addr < `FCPWM_OFF_CMP_HI0) begin
            rd_mux = cmp_lo_r[2'(reg_addr - `FCPWM_OFF_CMP_LO0)];
        end else if (reg_addr >= `FCPWM_OFF_CMP_HI0 && reg_addr < `FCPWM_OFF_IRQ_STAT) begin
            rd_mux = {6'h00, cmp_hi_r[2'(reg_addr - `FCPWM_OFF_CMP_HI0)]};
        end else if (reg_addr == `FCPWM_OFF_IRQ_STAT) begin
            rd_mux = {6'h00, irq_stat_r};
        end else if (reg_addr == `FCPWM_OFF_IRQ_MASK) begin
            rd_mux = {6'h00, irq_mask_r};
        end else begin
            rd_mux = cnt_r[7:0];
        end
    end

    wire irq_nxt = |(irq_stat_r & irq_mask_r) | (bkf_r & bkie_r);

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            reg_rdata <= 8'h00;
            irq <= 1'b0;
        end else if (clk_en) begin
            reg_rdata <= reg_rd ? rd_mux : 8'h00;
            irq <= irq_nxt;
        end
    end

endmodule
`default_nettype wire

// File: core/fcpwm_consts.svh
// Constants for the four-channel modulator with brake: offsets, fields, reset values.
`ifndef FCPWM_CONSTS_SVH
`define FCPWM_CONSTS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define FCPWM_ADDR_W 4
`define FCPWM_OFF_CTRL1 4'h0
`define FCPWM_OFF_CTRL2 4'h1
`define FCPWM_OFF_CTRL3 4'h2
`define FCPWM_OFF_PER_LO 4'h3
`define FCPWM_OFF_PER_HI 4'h4
`define FCPWM_OFF_CMP_LO0 4'h5
`define FCPWM_OFF_CMP_HI0 4'h9
`define FCPWM_OFF_IRQ_STAT 4'hd
`define FCPWM_OFF_IRQ_MASK 4'he
`define FCPWM_OFF_COUNT 4'hf

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define FCPWM_BIT_RUN 7
`define FCPWM_BIT_LOAD 6
`define FCPWM_BIT_UF 5
`define FCPWM_BIT_SWBRK 0
`define FCPWM_BIT_BRAKE_POLARITY_SELECT 6
`define FCPWM_BIT_BKF 0
`define FCPWM_BIT_BKIE 1
`define FCPWM_IRQ_UF 0
`define FCPWM_IRQ_BRK 1

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define FCPWM_PERIOD_RST 10'h3ff
`define FCPWM_CMP_RST 10'h000

`endif

// File: core/fcpwm_pkg.sv
// Types shared by the four-channel modulator.
package fcpwm_pkg;
    typedef logic [9:0] fcpwm_cnt_t;
    typedef enum logic [1:0] {FCPWM_IDLE, FCPWM_RUN, FCPWM_BRAKE} fcpwm_state_t;
endpackage

// File: sim/fcpwm_chk.sv
// Port checker for the four-channel modulator.
`timescale 1ns/10ps
`default_nettype none
`include "fcpwm_consts.svh"
module fcpwm_chk #(
    parameter int CHANNELS = 4
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic brake_pin,
    input wire logic [`FCPWM_ADDR_W-1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic [CHANNELS-1:0] pwm_out,
    input wire logic irq
);
    // Shadows of the brake polarity, brake interrupt enable and mask, taken from accepted writes.
    logic pol_r, bkie_r;
    logic [1:0] mask_r;
    wire logic brk = brake_pin == pol_r;
    wire logic quiet = mask_r == 2'b00 && !bkie_r;
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            pol_r <= 1'b0;
            bkie_r <= 1'b0;
            mask_r <= 2'b00;
        end else if (reg_wr && clk_en) begin
            if (reg_addr == `FCPWM_OFF_CTRL2) pol_r <= reg_wdata[`FCPWM_BIT_BRAKE_POLARITY_SELECT];
            if (reg_addr == `FCPWM_OFF_CTRL3) bkie_r <= reg_wdata[`FCPWM_BIT_BKIE];
            if (reg_addr == `FCPWM_OFF_IRQ_MASK) mask_r <= reg_wdata[1:0];
        end
    end
    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);
    property p_rdata_idle;
        $past(clk_en) && !$past(reg_rd) |-> reg_rdata == 8'h00;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data not zero");
    property p_reset_out;
        $past(clk_en) && !$past(rst_n) |-> pwm_out == '0 && !irq;
    endproperty
    a_reset_out: assert property (p_reset_out) else $error("outputs not cleared by reset");
    property p_en_freeze;
        !$past(clk_en) |-> $stable(pwm_out) && $stable(irq);
    endproperty
    a_en_freeze: assert property (p_en_freeze) else $error("outputs moved while disabled");
    property p_brake_freeze;
        brk [*6] |-> $stable(pwm_out);
    endproperty
    a_brake_freeze: assert property (p_brake_freeze) else $error("outputs moved in brake");
    property p_brake_irq;
        (bkie_r && brk) [*6] |-> irq;
    endproperty
    a_brake_irq: assert property (p_brake_irq) else $error("no interrupt in brake");
    property p_irq_quiet;
        $past(clk_en) && quiet && $past(quiet) |-> !irq;
    endproperty
    a_irq_quiet: assert property (p_irq_quiet) else $error("interrupt while all masked");
    property p_irq_sticky;
        irq && !reg_wr && !$past(reg_wr) |=> irq;
    endproperty
    a_irq_sticky: assert property (p_irq_sticky) else $error("interrupt dropped without a write");
    property p_bkf_read;
        brk [*6] ##0 (reg_rd && clk_en && reg_addr == `FCPWM_OFF_CTRL3) |=> reg_rdata[`FCPWM_BIT_BKF];
    endproperty
    a_bkf_read: assert property (p_bkf_read) else $error("brake flag reads clear in brake");
endmodule
bind fcpwm_top fcpwm_chk #(.CHANNELS(CHANNELS)) fcpwm_chk_i (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en),
    .brake_pin(brake_pin), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .pwm_out(pwm_out), .irq(irq));
`default_nettype wire

// File: sim/fcpwm_load_model.sv
// Model of the output loads and the external brake source.
`timescale 1ns/10ps
`default_nettype none
module fcpwm_load_model (
    input wire logic sys_clk,
    input wire logic [3:0] pwm_out,
    input wire logic brake_on,
    input wire logic brake_level,
    output logic brake_pin,
    output logic [3:0][15:0] hi_len,
    output logic [3:0][15:0] per_len
);
    logic [3:0][15:0] hi_r, cnt_r;
    logic [3:0] last_r;
    // Brake requests are held for many cycles, so polling never misses them.
    assign brake_pin = brake_on ? brake_level : ~brake_level;
    // Each load measures its high time and the time between rising edges.
    always_ff @(posedge sys_clk) begin
        last_r <= pwm_out;
        for (int i = 0; i < 4; i++) begin
            cnt_r[i] <= cnt_r[i] + 16'h1;
            hi_r[i] <= pwm_out[i] ? hi_r[i] + 16'h1 : 16'h0;
            if (pwm_out[i] && !last_r[i]) begin
                per_len[i] <= cnt_r[i];
                cnt_r[i] <= 16'h1;
            end
            if (!pwm_out[i] && last_r[i]) hi_len[i] <= hi_r[i];
        end
    end
endmodule
`default_nettype wire

// File: sim/fcpwm_top_test.sv
// Self-checking bench for the four-channel modulator.
`timescale 1ns/10ps
`default_nettype none
module fcpwm_top_test;
    logic sys_clk = 1'b0, rst_n = 1'b0, clk_en = 1'b1, strap = 1'b0, brake_on = 1'b0, brake_level = 1'b0;
    logic reg_wr = 1'b0, reg_rd = 1'b0, rd_d = 1'b0, brake_pin, irq;
    logic [3:0] reg_addr = 4'h0, pwm_out, snap;
    logic [7:0] reg_wdata = 8'h00, reg_rdata;
    logic [3:0][15:0] hi_len, per_len;
    logic [15:0] exp_q[$];
    logic [31:0] seed = 32'h6e46;
    logic [9:0] c1;
    logic [9:0] cmp [4];
    logic [1:0] seen;
    int errors = 0, comparisons = 0, cycles = 0;
    always #4 sys_clk = ~sys_clk;
    fcpwm_top fcpwm_top_i (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en), .reset_level_high_select(strap),
        .brake_pin(brake_pin), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .pwm_out(pwm_out), .irq(irq));
    fcpwm_load_model fcpwm_load_model_i (.sys_clk(sys_clk), .pwm_out(pwm_out), .brake_on(brake_on),
        .brake_level(brake_level), .brake_pin(brake_pin), .hi_len(hi_len), .per_len(per_len));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic check(input string name, input logic [15:0] seen_v, input logic [15:0] exp_v);
        comparisons++;
        if (seen_v !== exp_v) begin
            errors++;
            $display("unexpected %s: expected %h, seen %h", name, exp_v, seen_v);
        end
    endtask
    task automatic summarize();
        if (errors == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    // A read notes the bits to compare in the upper byte and their expected values in the lower.
    task automatic rd(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
        @(posedge sys_clk);
        exp_q.push_back({m, e});
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
    endtask
    always @(posedge sys_clk) begin
        logic [15:0] n;
        rd_d <= reg_rd;
        cycles++;
        if (cycles == 8000) begin
            errors++;
            summarize();
        end
        if (rd_d) begin
            n = exp_q.pop_front();
            check("reg_rdata", {8'h00, reg_rdata & n[15:8]}, {8'h00, n[7:0] & n[15:8]});
        end
    end
    initial begin
        for (int s = 0; s < 2; s++) begin
            rst_n <= 1'b0;
            strap <= s[0];
            tick(4);
            rst_n <= 1'b1;
            tick(5);
            check("reset level", {12'h0, pwm_out}, {12'h0, {4{s[0]}}});
        end
        seed = lfsr(seed);
        c1 = 10'd1 + {7'h0, seed[2:0]};
        cmp = '{10'h000, c1, 10'h009, 10'h3ff};
        wr(4'h3, 8'h09);
        wr(4'h4, 8'h00);
        for (int n = 0; n < 4; n++) begin
            wr(4'h5 + 4'(n), cmp[n][7:0]);
            wr(4'h9 + 4'(n), {6'h00, cmp[n][9:8]});
        end
        wr(4'h0, 8'hc0);
        tick(2300);
        check("period ch1", per_len[1], 16'd10);
        check("high ch1", hi_len[1], 16'd10 - {6'h0, c1});
        check("high ch2", hi_len[2], 16'd1);
        rd(4'h0, 8'he0, 8'ha0);
        seen = 2'b00;
        repeat (30) begin
            @(posedge sys_clk);
            seen = seen | {~pwm_out[0], pwm_out[3]};
        end
        check("stuck outputs", {14'h0, seen}, 16'h0);
        clk_en <= 1'b0;
        tick(5);
        clk_en <= 1'b1;
        wr(4'h3, 8'h0f);
        wr(4'h7, 8'h05);
        tick(40);
        check("period unloaded", per_len[1], 16'd10);
        check("high ch2 unloaded", hi_len[2], 16'd1);
        wr(4'h0, 8'he0);
        tick(60);
        check("period loaded", per_len[1], 16'd16);
        check("high ch2 loaded", hi_len[2], 16'd11);
        wr(4'he, 8'h01);
        tick(20);
        check("irq on underflow", {15'h0, irq}, 16'h1);
        rd(4'hd, 8'h01, 8'h01);
        wr(4'he, 8'h00);
        wr(4'hd, 8'h03);
        tick(3);
        check("irq masked", {15'h0, irq}, 16'h0);
        for (int p = 0; p < 2; p++) begin
            brake_level <= p[0];
            tick(4);
            wr(4'h1, {1'b0, p[0], 6'h00});
            wr(4'h2, 8'h02);
            wr(4'h0, 8'h80);
            tick(30);
            brake_on <= 1'b1;
            tick(8);
            snap = pwm_out;
            tick(20);
            check("frozen outputs", {12'h0, pwm_out}, {12'h0, snap});
            check("brake irq", {15'h0, irq}, 16'h1);
            rd(4'h0, 8'h80, 8'h00);
            rd(4'h2, 8'h01, 8'h01);
            brake_on <= 1'b0;
            tick(6);
            check("resumed outputs", {12'h0, pwm_out}, {12'h0, snap});
        end
        wr(4'h0, 8'h80);
        tick(25);
        wr(4'h1, 8'h41);
        tick(4);
        snap = pwm_out;
        tick(20);
        check("sw brake outputs", {12'h0, pwm_out}, {12'h0, snap});
        rd(4'h0, 8'h80, 8'h80);
        wr(4'h1, 8'h40);
        tick(4);
        summarize();
    end
endmodule
`default_nettype wire
